// ---- pin_matrix_pkg.sv ----
// constants and carrier types for the priority pin crossbar
// assumes sixteen port pins, port zero in bits 7:0, port one in bits 15:8

package pin_matrix_pkg;

   localparam int PIN_COUNT   = 16;
   localparam int FUNC_COUNT  = 17;
   localparam int STAGE_COUNT = 15;

   // function indices in priority order
   localparam int FN_TX     = 0;
   localparam int FN_RX     = 1;
   localparam int FN_SCK    = 2;
   localparam int FN_MISO   = 3;
   localparam int FN_MOSI   = 4;
   localparam int FN_NSS    = 5;
   localparam int FN_SDA    = 6;
   localparam int FN_SCL    = 7;
   localparam int FN_CMP    = 8;
   localparam int FN_CMPA   = 9;
   localparam int FN_SYSTEM_CLOCK_OUTPUT = 10;
   localparam int FN_COUNTER_ARRAY_CHANNEL_ZERO   = 11;
   localparam int FN_COUNTER_ARRAY_CHANNEL_ONE   = 12;
   localparam int FN_COUNTER_ARRAY_CHANNEL_TWO   = 13;
   localparam int FN_ECI    = 14;
   localparam int FN_T0     = 15;
   localparam int FN_T1     = 16;

   // allocation stage k serves function k + STAGE_BASE
   localparam int STAGE_BASE = 2;
   localparam int STAGE_SDA  = 4;
   localparam int STAGE_SCL  = 5;
   localparam int STAGE_NEXT = 6;

   localparam logic [15:0] TX_PIN_MASK = 16'h0010;
   localparam logic [15:0] RX_PIN_MASK = 16'h0020;

   localparam logic [1:0] WIRE_MODE_THREE = 2'h0;

   localparam logic [2:0] ROUTE_NONE  = 3'h0;
   localparam logic [2:0] ROUTE_CH0   = 3'h1;
   localparam logic [2:0] ROUTE_CH01  = 3'h2;
   localparam logic [2:0] ROUTE_CH012 = 3'h3;

   localparam logic [15:0] PINS_RESET  = 16'h0000;
   // pads rest on their pull-ups, so the edge history starts high
   localparam logic [15:0] PADS_IDLE   = 16'hFFFF;
   localparam logic [16:0] FUNCS_RESET = 17'h00000;

   typedef struct packed {
      logic       uart_en;
      logic       spi_en;
      logic       smbus_en;
      logic       cmp_en;
      logic       cmp_async_en;
      logic       system_clock_output_en;
      logic [2:0] counter_channel_route;
      logic       eci_en;
      logic       t0_en;
      logic       t1_en;
   } route_cfg_t;

   typedef struct packed {
      logic [15:0] pin_skip_bits;
      logic [15:0] output_mode_bits;
      logic [15:0] analog_digital_select;
   } pin_cfg_t;

endpackage

// ---- lane_allocator.sv ----
// one allocation stage: grants the lowest free pin to a request
// assumes the free mask comes from the previous stage of the chain
`timescale 1ns/1ps
`default_nettype none

module lane_allocator #(
   parameter int N = 16
) (
   // chain in
   input  wire logic [N-1:0] free_in,
   input  wire logic         req,
   // chain out
   output logic      [N-1:0] grant,
   output logic              found,
   output logic      [N-1:0] free_out
);

   wire [N-1:0] lowest = free_in & (~free_in + {{(N-1){1'b0}}, 1'b1});

   assign grant    = req ? lowest : '0;
   assign found    = |grant;
   assign free_out = free_in & ~grant;

endmodule
`default_nettype wire

// ---- priority_pin_crossbar.sv ----
// priority crossbar: places peripheral signals onto sixteen port pins
// and captures pin edges for the external interrupts and pin levels for the port match
// assumes peripheral and gpio signals arrive on ref_clk; pins are async
`timescale 1ns/1ps
`default_nettype none

module priority_pin_crossbar (
   // clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        arst_n,
   // configuration
   input  wire logic                        matrix_global_enable,
   input  wire pin_matrix_pkg::route_cfg_t  route_cfg,
   input  wire pin_matrix_pkg::pin_cfg_t    pin_cfg,
   input  wire logic [1:0]                  slave_select_wire_mode,
   // peripheral side
   input  wire logic [16:0]                 periph_out,
   input  wire logic [16:0]                 periph_drive,
   output logic      [16:0]                 periph_in,
   input  wire logic [15:0]                 gpio_out,
   input  wire logic [15:0]                 gpio_drive,
   output logic      [15:0]                 gpio_in,
   // pins
   input  wire logic [15:0]                 pin_i,
   output logic      [15:0]                 pin_o,
   output logic      [15:0]                 pin_oe,
   // event capture
   input  wire logic [2:0]                  ext_irq_pin_select_zero,
   input  wire logic [2:0]                  ext_irq_pin_select_one,
   input  wire logic [7:0]                  port_zero_match_mask,
   input  wire logic [7:0]                  port_zero_match_value,
   input  wire logic [7:0]                  port_one_match_mask,
   input  wire logic [7:0]                  port_one_match_value,
   output logic                             ext_irq_zero_event,
   output logic                             ext_irq_one_event,
   output logic                             port_mismatch,
   // status
   output logic      [16:0]                 func_routed,
   output logic      [15:0]                 pin_claimed
);

   // ----------------------------------------------------------------
   // requests
   // ----------------------------------------------------------------
   wire       en        = matrix_global_enable;
   wire [2:0] cex_route = route_cfg.counter_channel_route;
   wire       four_wire = slave_select_wire_mode
                          != pin_matrix_pkg::WIRE_MODE_THREE;
   wire       spi_req   = en & route_cfg.spi_en;
   wire       smb_req   = en & route_cfg.smbus_en;
   wire       uart_req  = en & route_cfg.uart_en;
   // reserved codes route no channel
   wire counter_array_channel_zero_req = en & ((cex_route == pin_matrix_pkg::ROUTE_CH0)
                      | (cex_route == pin_matrix_pkg::ROUTE_CH01)
                      | (cex_route == pin_matrix_pkg::ROUTE_CH012));
   wire counter_array_channel_one_req = en & ((cex_route == pin_matrix_pkg::ROUTE_CH01)
                      | (cex_route == pin_matrix_pkg::ROUTE_CH012));
   wire counter_array_channel_two_req = en & (cex_route == pin_matrix_pkg::ROUTE_CH012);

   // stage order is the priority order
   wire [14:0] stage_req = {
      en & route_cfg.t1_en,
      en & route_cfg.t0_en,
      en & route_cfg.eci_en,
      counter_array_channel_two_req,
      counter_array_channel_one_req,
      counter_array_channel_zero_req,
      en & route_cfg.system_clock_output_en,
      en & route_cfg.cmp_async_en,
      en & route_cfg.cmp_en,
      smb_req,
      smb_req,
      spi_req & four_wire,
      spi_req,
      spi_req,
      spi_req};

   // ----------------------------------------------------------------
   // allocation chain
   // ----------------------------------------------------------------
   // uart pins are taken out of the pool before any other grant
   wire [15:0] uart_pins = uart_req ? (pin_matrix_pkg::TX_PIN_MASK
                                     | pin_matrix_pkg::RX_PIN_MASK)
                                    : pin_matrix_pkg::PINS_RESET;
   wire [15:0] pool = ~pin_cfg.pin_skip_bits & ~uart_pins;

   logic [15:0] chain_free [0:15];
   logic [15:0] raw_grant  [0:14];
   logic [14:0] raw_found;
   logic [15:0] owner      [0:16];
   wire         pair_ok = raw_found[pin_matrix_pkg::STAGE_SDA]
                        & raw_found[pin_matrix_pkg::STAGE_SCL];

   assign chain_free[0] = pool;
   assign owner[pin_matrix_pkg::FN_TX] =
      uart_req ? pin_matrix_pkg::TX_PIN_MASK : pin_matrix_pkg::PINS_RESET;
   assign owner[pin_matrix_pkg::FN_RX] =
      uart_req ? pin_matrix_pkg::RX_PIN_MASK : pin_matrix_pkg::PINS_RESET;

   // purely combinational: grants follow the settings directly
   genvar k;
   generate
      for (k = 0; k < pin_matrix_pkg::STAGE_COUNT; k++) begin : g_stage
         wire [15:0] free_in;
         wire        is_pair = (k == pin_matrix_pkg::STAGE_SDA)
                             | (k == pin_matrix_pkg::STAGE_SCL);
         // a failed pair gives its pins back to later signals
         if (k == pin_matrix_pkg::STAGE_NEXT) begin : g_after_pair
            assign free_in = pair_ok ? chain_free[k]
                                     : chain_free[pin_matrix_pkg::STAGE_SDA];
         end else begin : g_plain
            assign free_in = chain_free[k];
         end
         lane_allocator #(.N(pin_matrix_pkg::PIN_COUNT)) u_lane (
            .free_in  (free_in),
            .req      (stage_req[k]),
            .grant    (raw_grant[k]),
            .found    (raw_found[k]),
            .free_out (chain_free[k+1])
         );
         assign owner[k + pin_matrix_pkg::STAGE_BASE] =
            (is_pair && !pair_ok) ? pin_matrix_pkg::PINS_RESET : raw_grant[k];
      end
   endgenerate

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   logic [15:0] claimed;
   logic [15:0] per_val;
   logic [15:0] per_drv;
   logic [16:0] routed;

   always_comb begin
      claimed = '0;
      per_val = '0;
      per_drv = '0;
      routed  = '0;
      for (int f = 0; f < pin_matrix_pkg::FUNC_COUNT; f++) begin
         claimed   = claimed | owner[f];
         per_val   = per_val | (owner[f] & {16{periph_out[f]}});
         per_drv   = per_drv | (owner[f] & {16{periph_drive[f]}});
         routed[f] = |owner[f];
      end
   end

   wire [15:0] smb_pins = owner[pin_matrix_pkg::FN_SDA]
                        | owner[pin_matrix_pkg::FN_SCL];
   wire [15:0] digital  = pin_cfg.analog_digital_select;
   // unclaimed pins fall back to gpio
   wire [15:0] out_val  = (claimed & per_val) | (~claimed & gpio_out);
   wire [15:0] out_drv  = (claimed & per_drv) | (~claimed & gpio_drive);
   wire [15:0] push     = pin_cfg.output_mode_bits & ~smb_pins;
   // open drain only pulls low; analog pins never drive
   assign pin_o  = out_val;
   assign pin_oe = {16{en}} & digital & out_drv
                 & (push | ~out_val);

   // ----------------------------------------------------------------
   // input capture
   // ----------------------------------------------------------------
   logic [15:0] pin_meta_r;
   logic [15:0] pin_sync_r;
   logic [15:0] level_prev_r;
   logic [16:0] periph_in_nxt;

   // analog pins read as zero; masking the edge too keeps a pin that is
   // switched to analog while high from raising a capture event
   wire [15:0] level  = pin_sync_r & digital;
   wire [15:0] edges  = (level ^ level_prev_r) & digital;
   // an analog pin takes no part in the match compare
   wire [15:0] mmask  = {port_one_match_mask, port_zero_match_mask}
                      & digital;
   wire [15:0] mvalue = {port_one_match_value, port_zero_match_value};

   always_comb begin
      periph_in_nxt = '0;
      for (int f = 0; f < pin_matrix_pkg::FUNC_COUNT; f++) begin
         periph_in_nxt[f] = |(owner[f] & level);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // idle pads are high; a low start would fake an edge after reset
         pin_meta_r   <= pin_matrix_pkg::PADS_IDLE;
         pin_sync_r   <= pin_matrix_pkg::PADS_IDLE;
         level_prev_r <= pin_matrix_pkg::PADS_IDLE;
      end else begin
         pin_meta_r   <= pin_i;
         pin_sync_r   <= pin_meta_r;
         level_prev_r <= level;
      end
   end

   // capture sees digital pins owned by the crossbar or not; the interrupts select among pins 7:0 only
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_irq_zero_event <= 1'b0;
         ext_irq_one_event  <= 1'b0;
         port_mismatch      <= 1'b0;
      end else begin
         ext_irq_zero_event <= edges[ext_irq_pin_select_zero];
         ext_irq_one_event  <= edges[ext_irq_pin_select_one];
         port_mismatch      <= |((level ^ mvalue) & mmask);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         periph_in   <= pin_matrix_pkg::FUNCS_RESET;
         gpio_in     <= pin_matrix_pkg::PINS_RESET;
         func_routed <= pin_matrix_pkg::FUNCS_RESET;
         pin_claimed <= pin_matrix_pkg::PINS_RESET;
      end else begin
         periph_in   <= periph_in_nxt;
         gpio_in     <= level;
         func_routed <= routed;
         pin_claimed <= claimed;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence sel_zero_analog_s;
      (!digital[ext_irq_pin_select_zero]
       && $stable(ext_irq_pin_select_zero))[*3];
   endsequence

   uart_fixed_a: assert property (uart_req |->
      owner[pin_matrix_pkg::FN_TX] == pin_matrix_pkg::TX_PIN_MASK
      && owner[pin_matrix_pkg::FN_RX] == pin_matrix_pkg::RX_PIN_MASK)
      else $error("serial pins not fixed");
   skip_respect_a: assert property (
      ((claimed & ~uart_pins) & pin_cfg.pin_skip_bits) == 16'h0000)
      else $error("skipped pin granted");
   sck_lowest_a: assert property (spi_req |->
      owner[pin_matrix_pkg::FN_SCK] == (pool & (~pool + 16'h0001)))
      else $error("clock not on lowest free pin");
   smb_pair_a: assert property (
      routed[pin_matrix_pkg::FN_SDA] == routed[pin_matrix_pkg::FN_SCL])
      else $error("bus line granted alone");
   nss_mode_a: assert property (!four_wire |->
      owner[pin_matrix_pkg::FN_NSS] == pin_matrix_pkg::PINS_RESET)
      else $error("select placed in three-wire mode");
   drivers_off_a: assert property (!en |-> pin_oe == 16'h0000)
      else $error("driver on while disabled");
   od_force_a: assert property (
      (pin_oe & smb_pins & pin_o) == 16'h0000)
      else $error("bus pin driven high");
   cex_reserved_a: assert property (cex_route[2] |->
      !routed[pin_matrix_pkg::FN_COUNTER_ARRAY_CHANNEL_ZERO])
      else $error("reserved code routed a channel");
   analog_quiet_a: assert property (sel_zero_analog_s |->
      !edges[ext_irq_pin_select_zero] ##1 !ext_irq_zero_event)
      else $error("event from analog pin");
   edge_event_a: assert property (edges[ext_irq_pin_select_one] |=>
      ext_irq_one_event)
      else $error("edge missed");

endmodule
`default_nettype wire

// ---- pin_pad_model.sv ----
// pad model: resolves crossbar drive and external drive onto each pad
// assumes weak pull-ups on every pad; external drive only where oe is 0
`timescale 1ns/1ps
`default_nettype none

module pin_pad_model (
   // crossbar side
   input  wire logic [15:0] pin_o,
   input  wire logic [15:0] pin_oe,
   // external world
   input  wire logic [15:0] ext_en,
   input  wire logic [15:0] ext_val,
   // pads seen by the crossbar
   output logic      [15:0] pin_i
);
   // -------------------------------------------------
   // pad resolution
   // -------------------------------------------------
   // a released pad goes to the pull-up level, never keeps the last value
   always_comb begin
      for (int p = 0; p < 16; p++) begin
         if (pin_oe[p])
            pin_i[p] = pin_o[p];
         else if (ext_en[p])
            pin_i[p] = ext_val[p];
         else
            pin_i[p] = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- priority_pin_crossbar_test.sv ----
// self-checking bench for the priority pin crossbar
// assumes the pad model closes the loop from pin_o/pin_oe to pin_i
`timescale 1ns/1ps
`default_nettype none

module priority_pin_crossbar_test;
   logic                       ref_clk, arst_n, en;
   pin_matrix_pkg::route_cfg_t route_cfg;
   pin_matrix_pkg::pin_cfg_t   pin_cfg;
   logic [1:0]                 wire_mode;
   logic [16:0]                periph_out, periph_drive, periph_in;
   logic [16:0]                func_routed, e_routed, e_in;
   logic [15:0]                gpio_out, gpio_drive, gpio_in, pin_i, pin_o;
   logic [15:0]                pin_oe, pin_claimed, ext_en, ext_val;
   logic [15:0]                e_claim, e_oe, e_o, e_pad;
   logic [7:0]                 mask0, val0;
   logic                       ev0, ev1, mism;
   int                         error_cnt, check_count, cyc;
   int                         owner [16];

   priority_pin_crossbar i_priority_pin_crossbar (
      .ref_clk(ref_clk), .arst_n(arst_n), .matrix_global_enable(en),
      .route_cfg(route_cfg), .pin_cfg(pin_cfg),
      .slave_select_wire_mode(wire_mode), .periph_out(periph_out),
      .periph_drive(periph_drive), .periph_in(periph_in),
      .gpio_out(gpio_out), .gpio_drive(gpio_drive), .gpio_in(gpio_in),
      .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
      .ext_irq_pin_select_zero(3'h3), .ext_irq_pin_select_one(3'h3),
      .port_zero_match_mask(mask0), .port_zero_match_value(val0),
      .port_one_match_mask(8'h00), .port_one_match_value(8'h00),
      .ext_irq_zero_event(ev0), .ext_irq_one_event(ev1),
      .port_mismatch(mism), .func_routed(func_routed),
      .pin_claimed(pin_claimed));

   pin_pad_model i_pin_pad_model (
      .pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
      .pin_i(pin_i));

   // -------------------------------------------------
   // reference placement
   // -------------------------------------------------
   task automatic calc();
      logic [15:0] free;
      logic [16:0] req;
      logic        od;
      free = ~pin_cfg.pin_skip_bits;
      req = '0;
      e_routed = '0;
      e_claim = '0;
      e_in = '0;
      for (int i = 0; i < 16; i++) owner[i] = -1;
      if (en) begin
         req[1:0] = {2{route_cfg.uart_en}};
         req[4:2] = {3{route_cfg.spi_en}};
         req[5] = route_cfg.spi_en & (wire_mode != 2'h0);
         req[7:6] = {2{route_cfg.smbus_en}};
         req[10:8] = {route_cfg.system_clock_output_en, route_cfg.cmp_async_en,
                      route_cfg.cmp_en};
         req[11] = route_cfg.counter_channel_route inside {3'h1, 3'h2, 3'h3};
         req[12] = route_cfg.counter_channel_route inside {3'h2, 3'h3};
         req[13] = route_cfg.counter_channel_route == 3'h3;
         req[16:14] = {route_cfg.t1_en, route_cfg.t0_en, route_cfg.eci_en};
      end
      if (req[0]) begin
         owner[4] = 0;
         owner[5] = 1;
         free[5:4] = 2'h0;
      end
      // the two-wire pair is placed whole or dropped, freeing both pins
      for (int f = 2; f < 17; f++) begin
         if (f == 6 && $countones(free) < 2) req[7:6] = 2'h0;
         for (int p = 0; p < 16; p++) begin
            if (req[f] && free[p]) begin
               owner[p] = f;
               free[p] = 1'b0;
               req[f] = 1'b0;
            end
         end
      end
      for (int p = 0; p < 16; p++) begin
         od = owner[p] == 6 || owner[p] == 7 || !pin_cfg.output_mode_bits[p];
         if (owner[p] >= 0) begin
            e_claim[p] = 1'b1;
            e_routed[owner[p]] = 1'b1;
            e_o[p] = periph_out[owner[p]];
            e_oe[p] = periph_drive[owner[p]];
         end else begin
            e_o[p] = gpio_out[p];
            e_oe[p] = gpio_drive[p];
         end
         // analog pins and open-drain highs never drive
         e_oe[p] = en & pin_cfg.analog_digital_select[p] & e_oe[p]
                   & !(od & e_o[p]);
         // analog pins read back zero
         e_pad[p] = (e_oe[p] ? e_o[p] : 1'b1)
                    & pin_cfg.analog_digital_select[p];
         if (owner[p] >= 0) e_in[owner[p]] = e_pad[p];
      end
   endtask

   // -------------------------------------------------
   // access and compare tasks
   // -------------------------------------------------
   task automatic chk(string name, logic [16:0] exp, logic [16:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apply(logic e, logic [11:0] rc, logic [15:0] sk,
                        logic [1:0] wm);
      @(negedge ref_clk);
      en = e;
      route_cfg = rc;
      pin_cfg.pin_skip_bits = sk;
      wire_mode = wm;
      calc();
      repeat (4) @(negedge ref_clk);
      chk("pin_oe", {1'b0, e_oe}, {1'b0, pin_oe});
      chk("pin_o", {1'b0, e_o & e_oe}, {1'b0, pin_o & pin_oe});
      chk("pin_claimed", {1'b0, e_claim}, {1'b0, pin_claimed});
      chk("func_routed", e_routed, func_routed);
      chk("periph_in", e_in, periph_in);
      chk("gpio_in", {1'b0, e_pad}, {1'b0, gpio_in});
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // -------------------------------------------------
   // clock, timeout and sequence
   // -------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // the whole run needs about 130 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         error_cnt++;
         finish_test();
      end
   end

   initial begin
      {error_cnt, check_count, cyc} = '0;
      arst_n = 1'b0;
      en = 1'b0;
      route_cfg = '0;
      pin_cfg = {16'h0000, 16'hFFFF, 16'hFFFF};
      wire_mode = 2'h0;
      periph_out = 17'h0A543;
      periph_drive = 17'h1FFFD;
      gpio_out = 16'h5A5A;
      gpio_drive = 16'hFFFF;
      {ext_en, ext_val, mask0, val0} = '0;
      repeat (20) @(negedge ref_clk);
      arst_n = 1'b1;
      // pads idle high, so no edge may be reported as capture starts
      repeat (4) begin
         @(negedge ref_clk);
         chk("irq_zero", 17'h0, {16'h0, ev0});
         chk("irq_one", 17'h0, {16'h0, ev1});
      end
      apply(1'b0, 12'hFDF, 16'h0000, 2'h1);
      apply(1'b1, 12'h600, 16'h0000, 2'h1);
      apply(1'b1, 12'h600, 16'h0000, 2'h0);
      apply(1'b1, 12'hFDF, 16'h130C, 2'h1);
      apply(1'b1, 12'hFDF, 16'h0030, 2'h1);
      apply(1'b1, 12'h700, 16'hFFE8, 2'h0);
      apply(1'b1, 12'hFFF, 16'h0000, 2'h1);
      // open-drain on half the pins, and the counter clock pin analog
      pin_cfg.output_mode_bits = 16'h0F0F;
      pin_cfg.analog_digital_select = 16'hBFFF;
      apply(1'b1, 12'hFDF, 16'h0000, 2'h1);
      pin_cfg.output_mode_bits = 16'hFFFF;
      pin_cfg.analog_digital_select = 16'hFFFF;
      for (int r = 0; r < 8; r++) begin
         apply(1'b1, 12'h004 | (12'(r) << 3), 16'h0000, 2'h0);
      end
      // event capture on a pad driven from outside, crossbar off
      apply(1'b0, 12'h000, 16'h0000, 2'h0);
      mask0 = 8'h08;
      val0 = 8'h08;
      ext_en[3] = 1'b1;
      ext_val[3] = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("port_mismatch", 17'h0, {16'h0, mism});
      ext_val[3] = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("irq_one", 17'h1, {16'h0, ev1});
      chk("irq_zero", 17'h1, {16'h0, ev0});
      chk("port_mismatch", 17'h1, {16'h0, mism});
      @(negedge ref_clk);
      chk("irq_one", 17'h0, {16'h0, ev1});
      pin_cfg.analog_digital_select[3] = 1'b0;
      repeat (4) @(negedge ref_clk);
      ext_val[3] = 1'b1;
      repeat (6) begin
         @(negedge ref_clk);
         chk("irq_one", 17'h0, {16'h0, ev1});
         chk("gpio_in", 17'h0, {9'h0, gpio_in[7:0] & 8'h08});
         chk("port_mismatch", 17'h0, {16'h0, mism});
      end
      finish_test();
   end
endmodule
`default_nettype wire
